// ---- rtl/ctr_pkg.sv ----
// ctr_pkg: register indices, field positions and reset values for the
// channel 3/4 setup and trim register bank.
// assumes: 32-bit APB; byte address is four times the register index.
package ctr_pkg;

   // register indices (byte address = index * 4)
   localparam logic [7:0] IDX_CHAN2_GAIN_TRIM_LOW   = 8'h17;
   localparam logic [7:0] IDX_CHAN3_SETUP           = 8'h18;
   localparam logic [7:0] IDX_CHAN3_OFFSET_TRIM_HIGH = 8'h19;
   localparam logic [7:0] IDX_CHAN3_OFFSET_TRIM_LOW  = 8'h1A;
   localparam logic [7:0] IDX_CHAN3_GAIN_TRIM_HIGH  = 8'h1B;
   localparam logic [7:0] IDX_CHAN3_GAIN_TRIM_LOW   = 8'h1C;
   localparam logic [7:0] IDX_CHAN4_SETUP           = 8'h1D;
   localparam logic [7:0] IDX_CHAN4_OFFSET_TRIM_HIGH = 8'h1E;

   localparam int ADDR_LSB = 2;

   // setup word fields
   localparam int DELAY_MSB  = 15;
   localparam int DELAY_LSB  = 6;
   localparam int BYPASS_BIT = 2;
   localparam int SEL_MSB    = 1;
   localparam int SEL_LSB    = 0;
   localparam logic [15:0] SETUP_MASK = 16'hFFC7;
   // trim low words keep bits 15:8 only
   localparam logic [15:0] TRIM_LOW_MASK = 16'hFF00;
   localparam logic [15:0] FULL_MASK     = 16'hFFFF;

   localparam logic [15:0] RST_ZERO      = 16'h0000;
   localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;

   // input source selection
   typedef enum logic [1:0] {
      CTR_SRC_OWN_PINS = 2'h0,
      CTR_SRC_SHORTED  = 2'h1,
      CTR_SRC_POS_TEST = 2'h2,
      CTR_SRC_NEG_TEST = 2'h3
   } ctr_src_e;

   typedef struct packed {
      logic signed [9:0] delay_trim;
      logic              highpass_bypass;
      ctr_src_e          input_select;
   } ctr_setup_s;

   typedef struct packed {
      logic signed [23:0] offset_trim;
      logic        [23:0] gain_trim;
   } ctr_trim_s;

endpackage : ctr_pkg

// ---- rtl/ctr_word_reg.sv ----
// ctr_word_reg: one 16-bit software register with a write mask and reset.
// assumes: write strobe comes from the APB slave on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ctr_word_reg #(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
   input  wire logic        ref_clk,   // system clock
   input  wire logic        rst_b,     // async reset, active low
   input  wire logic        wr_en,     // write strobe
   input  wire logic [15:0] wr_data,   // write data
   output logic      [15:0] value      // stored word
);

   // masked bits stay at their reset value, so they read as that value
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         value <= RESET_VALUE;
      else if (wr_en)
         value <= (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
   end

endmodule : ctr_word_reg
`default_nettype wire

// ---- rtl/ctr_trim_regs.sv ----
// ctr_trim_regs: APB register bank for channel 3/4 setup words and the
// offset/gain trims, decoded into per-channel fields for the datapath.
// assumes: one clock; APB master keeps request stable until pready.
// Functional notes
// - setup bits 15:6 are a signed delay in modulator clock cycles.
// - setup bit 2 set bypasses channel highpass; clear follows global.
// - setup bits 1:0 pick own pins, shorted, positive or negative test.
// - offset trim 24-bit signed; high word is 23:8, low 15:8 is 7:0.
// - gain trim is unsigned 24 bits, zero to just under two.
// - gain high word is bits 23:8; low word 15:8 bits 7:0; 7:0 reserved.
// - gain trim high word resets to 8000h, unity gain.
// - setup, offset words and gain low word reset to 0000h.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ctr_trim_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,        // 50 MHz clock
   input  wire logic              rst_b,          // async reset, active low
   input  wire logic              psel,           // apb select
   input  wire logic              penable,        // apb access phase
   input  wire logic              pwrite,         // apb direction
   input  wire logic [ADDR_W-1:0] paddr,          // apb byte address
   input  wire logic [31:0]       pwdata,         // apb write data
   input  wire logic [3:0]        pstrb,          // apb byte strobes
   output logic      [31:0]       prdata,         // apb read data
   output logic                   pready,         // apb ready
   output logic                   pslverr,        // apb error
   output var ctr_pkg::ctr_setup_s chan3_setup,   // channel 3 decoded setup
   output var ctr_pkg::ctr_setup_s chan4_setup,   // channel 4 decoded setup
   output var ctr_pkg::ctr_trim_s  chan3_trim,    // channel 3 offset/gain
   output logic signed [15:0]     chan4_offset_upper, // chan 4 offset 23:8
   output logic      [7:0]        chan2_gain_trim_lower // chan 2 gain 7:0
);

   // the decoder compares a full byte of register index
   if (ADDR_W < 8)
   begin : g_addr_w_check
      $error("ctr_trim_regs: ADDR_W must be at least 8");
   end

   localparam int NREG = 8;

   logic [NREG-1:0]       wr_sel;
   logic [15:0]           word [NREG];
   logic [ADDR_W-1:0]     index;
   logic                  hit;
   logic [2:0]            slot;
   logic                  setup_phase;
   logic                  low_half_ok;
   logic [31:0]           next_prdata;

   assign index = paddr >> ctr_pkg::ADDR_LSB;
   assign setup_phase = psel && !penable;
   // only the low half carries data; a write missing either of pstrb[1:0] is dropped
   assign low_half_ok = pstrb[0] && pstrb[1];

   always_comb
   begin
      hit  = 1'b0;
      slot = 3'h0;
      // index bits above the byte must be clear; shifting keeps ADDR_W = 8 legal
      if (paddr[1:0] == 2'h0 && (index >> 8) == '0)
      begin
         hit = 1'b1;
         unique case (index[7:0])
            ctr_pkg::IDX_CHAN2_GAIN_TRIM_LOW:    slot = 3'h0;
            ctr_pkg::IDX_CHAN3_SETUP:            slot = 3'h1;
            ctr_pkg::IDX_CHAN3_OFFSET_TRIM_HIGH: slot = 3'h2;
            ctr_pkg::IDX_CHAN3_OFFSET_TRIM_LOW:  slot = 3'h3;
            ctr_pkg::IDX_CHAN3_GAIN_TRIM_HIGH:   slot = 3'h4;
            ctr_pkg::IDX_CHAN3_GAIN_TRIM_LOW:    slot = 3'h5;
            ctr_pkg::IDX_CHAN4_SETUP:            slot = 3'h6;
            ctr_pkg::IDX_CHAN4_OFFSET_TRIM_HIGH: slot = 3'h7;
            default:                             hit  = 1'b0;
         endcase
      end
   end

   // writes land on the access edge; the slave always answers with no wait
   // state so the access phase is exactly one cycle
   always_comb
   begin
      wr_sel = '0;
      if (psel && penable && pready && pwrite && hit && low_half_ok)
         wr_sel[slot] = 1'b1;
   end

   localparam logic [15:0] RESETS [NREG] = '{
      ctr_pkg::RST_ZERO, ctr_pkg::RST_ZERO, ctr_pkg::RST_ZERO,
      ctr_pkg::RST_ZERO, ctr_pkg::RST_GAIN_HIGH, ctr_pkg::RST_ZERO,
      ctr_pkg::RST_ZERO, ctr_pkg::RST_ZERO};
   localparam logic [15:0] MASKS [NREG] = '{
      ctr_pkg::TRIM_LOW_MASK, ctr_pkg::SETUP_MASK, ctr_pkg::FULL_MASK,
      ctr_pkg::TRIM_LOW_MASK, ctr_pkg::FULL_MASK, ctr_pkg::TRIM_LOW_MASK,
      ctr_pkg::SETUP_MASK, ctr_pkg::FULL_MASK};

   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_word
         ctr_word_reg #(
            .RESET_VALUE (RESETS[g]),
            .WRITE_MASK  (MASKS[g])
         ) u_word (
            .ref_clk (ref_clk),
            .rst_b   (rst_b),
            .wr_en   (wr_sel[g]),
            .wr_data (pwdata[15:0]),
            .value   (word[g])
         );
      end
   endgenerate

   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (hit)
         next_prdata = {16'h0000, word[slot]};
   end

   // ready rises in the first access cycle and drops after it
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         pready <= 1'b0;
      else
         pready <= setup_phase;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         prdata <= 32'h0000_0000;
      else if (setup_phase && !pwrite)
         prdata <= next_prdata;
   end

   // unmapped or misaligned address answers with an error
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         pslverr <= 1'b0;
      else
         pslverr <= setup_phase && !hit;
   end

   // decoded fields are registered so every output is a flip-flop;
   // they trail the stored word by one cycle
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         chan3_setup <= '0;
         chan4_setup <= '0;
      end
      else
      begin
         chan3_setup.delay_trim <=
            word[1][ctr_pkg::DELAY_MSB:ctr_pkg::DELAY_LSB];
         chan3_setup.highpass_bypass <=
            word[1][ctr_pkg::BYPASS_BIT];
         chan3_setup.input_select <= ctr_pkg::ctr_src_e'(
            word[1][ctr_pkg::SEL_MSB:ctr_pkg::SEL_LSB]);
         chan4_setup.delay_trim <=
            word[6][ctr_pkg::DELAY_MSB:ctr_pkg::DELAY_LSB];
         chan4_setup.highpass_bypass <=
            word[6][ctr_pkg::BYPASS_BIT];
         chan4_setup.input_select <= ctr_pkg::ctr_src_e'(
            word[6][ctr_pkg::SEL_MSB:ctr_pkg::SEL_LSB]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // gain shows unity during reset too, matching the stored words
         chan3_trim.offset_trim <= '0;
         chan3_trim.gain_trim   <=
            {ctr_pkg::RST_GAIN_HIGH, ctr_pkg::RST_ZERO[15:8]};
         chan4_offset_upper     <= '0;
         chan2_gain_trim_lower  <= '0;
      end
      else
      begin
         chan3_trim.offset_trim <= {word[2], word[3][15:8]};
         chan3_trim.gain_trim   <= {word[4], word[5][15:8]};
         chan4_offset_upper     <= word[7];
         chan2_gain_trim_lower    <= word[0][15:8];
      end
   end

endmodule : ctr_trim_regs
`default_nettype wire

// ---- test/ctr_trim_regs_sva.sv ----
// ctr_trim_regs_sva: port checks for the trim register bank.
// assumes: bound into ctr_trim_regs, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctr_trim_regs_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic              ref_clk,            // clock
   input wire logic              rst_b,              // reset, active low
   input wire logic              psel,               // apb select
   input wire logic              penable,            // apb access
   input wire logic              pwrite,             // apb direction
   input wire logic [ADDR_W-1:0] paddr,              // apb address
   input wire logic [31:0]       pwdata,             // apb write data
   input wire logic [3:0]        pstrb,              // apb strobes
   input wire logic [31:0]       prdata,             // apb read data
   input wire logic              pready,             // apb ready
   input wire ctr_pkg::ctr_setup_s chan3_setup,      // chan 3 setup
   input wire ctr_pkg::ctr_setup_s chan4_setup,      // chan 4 setup
   input wire ctr_pkg::ctr_trim_s  chan3_trim,       // chan 3 trims
   input wire logic signed [15:0]  chan4_offset_upper // chan 4 offset
);
   logic wr;
   logic rd;
   assign rd = psel & penable & pready & !pwrite;
   // writes missing either of pstrb[1:0] are dropped, so they are not checked here
   assign wr = psel & penable & pready & pwrite & (pstrb[1:0] == 2'h3);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   delay_field_a: assert property (
      wr && paddr == 8'h60 |-> ##2
      chan3_setup.delay_trim == $past(pwdata[15:6], 2))
      else $error("delay field not taken from setup write");
   bypass_bit_a: assert property (
      wr && paddr == 8'h60 |-> ##2
      chan3_setup.highpass_bypass == $past(pwdata[2], 2))
      else $error("bypass bit not taken from setup write");
   source_sel_a: assert property (
      wr && paddr == 8'h74 |-> ##2
      chan4_setup.input_select == $past(pwdata[1:0], 2))
      else $error("input select not taken from setup write");
   offset_high_a: assert property (
      wr && paddr == 8'h64 |-> ##2
      chan3_trim.offset_trim[23:8] == $past(pwdata[15:0], 2))
      else $error("offset high word not placed at bits 23:8");
   gain_low_a: assert property (
      wr && paddr == 8'h70 |-> ##2
      chan3_trim.gain_trim[7:0] == $past(pwdata[15:8], 2))
      else $error("gain low word not placed at bits 7:0");
   gain_reset_a: assert property (
      $rose(rst_b) |-> chan3_trim.gain_trim == 24'h800000)
      else $error("gain trim not at unity after reset");
   zero_reset_a: assert property (
      $rose(rst_b) |-> chan3_setup == '0 && chan3_trim.offset_trim == '0)
      else $error("setup or offset not zero after reset");
   low_reserved_a: assert property (
      rd && paddr == 8'h68 |-> prdata[7:0] == 8'h00)
      else $error("reserved low bits read nonzero");
   setup_reserved_a: assert property (
      rd && paddr == 8'h60 |-> prdata[5:3] == 3'h0)
      else $error("reserved setup bits read nonzero");
endmodule : ctr_trim_regs_sva

bind ctr_trim_regs ctr_trim_regs_sva #(.ADDR_W(ADDR_W)) ctr_trim_regs_sva_i (
   .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .chan3_setup, .chan4_setup, .chan3_trim,
   .chan4_offset_upper
);
`default_nettype wire

// ---- test/ctr_trim_regs_bench.sv ----
// ctr_trim_regs_bench: self-checking bench for the trim register bank.
// assumes: the bench is the apb master; no far-side model is needed.
`timescale 1ns/1ps
`default_nettype none
module ctr_trim_regs_bench;
   logic                ref_clk = 1'b0;
   logic                rst_b   = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [7:0]          paddr   = 8'h00;
   logic [31:0]         pwdata  = 32'h0;
   logic [3:0]          pstrb   = 4'hF;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   ctr_pkg::ctr_setup_s chan3_setup;
   ctr_pkg::ctr_setup_s chan4_setup;
   ctr_pkg::ctr_trim_s  chan3_trim;
   logic signed [15:0]  chan4_offset_upper;
   logic [7:0]          chan2_gain_trim_lower;
   logic [31:0]         q;
   logic                e;
   int                  fail_count = 0;
   int                  checks = 0;
   always #10 ref_clk = ~ref_clk;
   ctr_trim_regs #(.ADDR_W(8)) ctr_trim_regs_i (.ref_clk, .rst_b, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .chan3_setup, .chan4_setup, .chan3_trim, .chan4_offset_upper,
      .chan2_gain_trim_lower);
   task end_of_test;
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // waits an edge first so back-to-back calls never drive twice at once
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         fail_count++;
         end_of_test();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task t_reset;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'h5C + 8'(4 * i), 32'h0);
         chk(q, (i == 4) ? 32'h00008000 : 32'h0);
      end
      chk({8'h0, chan3_trim.gain_trim}, 32'h00800000);
   endtask : t_reset
   task t_setup;
      logic [12:0] v;
      for (int s = 0; s < 4; s++)
      begin
         // negative delays, both bypass values, every source
         v = {10'h201 ^ 10'(s), s[1], 2'(s)};
         apb(1'b1, 8'h60, {16'hFFFF, v[12:3], 3'h7, v[2:0]});
         apb(1'b1, 8'h74, {16'hFFFF, v[12:3], 3'h7, v[2:0]});
         repeat (2) @(posedge ref_clk);
         chk({19'h0, chan3_setup}, {19'h0, v});
         chk({19'h0, chan4_setup}, {19'h0, v});
         apb(1'b0, 8'h60, 32'h0);
         chk(q, {16'h0, v[12:3], 3'h0, v[2:0]});
      end
   endtask : t_setup
   task t_trims;
      apb(1'b1, 8'h64, 32'h00008001);
      apb(1'b1, 8'h68, 32'h0000ABCD);
      apb(1'b1, 8'h6C, 32'h00001234);
      apb(1'b1, 8'h70, 32'h000056FF);
      apb(1'b1, 8'h78, 32'h0000C3A5);
      apb(1'b1, 8'h5C, 32'h00009A7E);
      repeat (2) @(posedge ref_clk);
      chk({8'h0, chan3_trim.offset_trim}, 32'h008001AB);
      chk({8'h0, chan3_trim.gain_trim}, 32'h00123456);
      chk({16'h0, chan4_offset_upper}, 32'h0000C3A5);
      chk({24'h0, chan2_gain_trim_lower}, 32'h0000009A);
      apb(1'b0, 8'h70, 32'h0);
      chk(q, 32'h00005600);
      apb(1'b0, 8'h68, 32'h0);
      chk(q, 32'h0000AB00);
   endtask : t_trims
   task t_refused;
      pstrb <= 4'hC;
      apb(1'b1, 8'h64, 32'h00001111);
      pstrb <= 4'hF;
      apb(1'b0, 8'h64, 32'h0);
      chk(q, 32'h00008001);
      apb(1'b0, 8'h7C, 32'h0);
      chk({q[31:1], e}, 32'h00000001);
      // misaligned byte address inside the mapped range is refused too
      apb(1'b0, 8'h62, 32'h0);
      chk({q[31:1], e}, 32'h00000001);
   endtask : t_refused
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_setup();
      t_trims();
      t_refused();
      end_of_test();
   end
endmodule : ctr_trim_regs_bench
`default_nettype wire
